// *** bench/qdcc_host.sv ***
`timescale 1ns/1ps
module qdcc_host (
  // clock
  input wire logic clk,
  // framed words
  output logic     wordValid,
  output logic [23:0] wordData
);
  initial begin
    wordValid = 1'b0;
    wordData  = 24'h0;
  end
  task automatic send(input logic [23:0] w);
    @(posedge clk);
    wordValid <= 1'b1;
    wordData  <= {1'b0, w[22:0]};
    @(posedge clk);
    wordValid <= 1'b0;
    wordData  <= ~w;
  endtask
endmodule

// *** bench/qdcc_props.sv ***
`timescale 1ns/1ps
module qdcc_props
  import qdcc_pkg::*;
#(
  parameter int DATA_W = QDCC_DATA_W
) (
  // clock and reset
  input wire logic                clk,
  input wire logic                nrst,
  // inputs
  input wire logic                wordValid,
  input wire logic [23:0]         wordData,
  input wire logic                load_strobe_n,
  input wire logic                powerOnLevel,
  // outputs
  input wire logic [4*DATA_W-1:0] dacCodes,
  input wire logic [7:0]          powerModes,
  input wire logic [3:0]          channel_update_mask,
  input wire logic                reference_enable,
  input wire logic                inReset
);
  logic [2:0] c;
  logic       tk;
  assign c  = wordData[21:19];
  assign tk = wordValid && !inReset;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  function automatic logic [7:0] merge(input logic [7:0] o, input logic [3:0] s, input logic [1:0] m);
    for (int i = 0; i < 4; i++) begin
      if (s[i]) o[2*i +: 2] = m;
    end
    return o;
  endfunction
  sequence quiet_s;
    (load_strobe_n && !wordValid)[*5];
  endsequence
  sequence wr_d_s;
    tk && load_strobe_n && c == QDCC_CMD_WRITE_IN && wordData[18:16] == 3'h3 && !channel_update_mask[3];
  endsequence
  a_mask_load: assert property (
    tk && c == QDCC_CMD_LOADMASK |=> channel_update_mask == $past(wordData[3:0])) else $error("mask load");
  a_power_merge: assert property (
    tk && c == QDCC_CMD_POWER |=> powerModes == merge($past(powerModes), $past(wordData[3:0]),
    $past(wordData[5:4]))) else $error("power merge");
  a_ref_set: assert property (
    tk && c == QDCC_CMD_REFERENCE |=> reference_enable == $past(wordData[0])) else $error("reference");
  a_full_reset: assert property (
    tk && c == QDCC_CMD_RESET && wordData[0] |=> channel_update_mask == 4'h0 && powerModes == 8'h0
    && !reference_enable) else $error("full reset");
  a_dac_clear: assert property (
    tk && c == QDCC_CMD_RESET |-> ##2 dacCodes == '0) else $error("dac clear");
  a_idle_stable: assert property (
    !wordValid |=> $stable(channel_update_mask) && $stable(powerModes) && $stable(reference_enable))
    else $error("idle change");
  a_async_hold: assert property (
    quiet_s ##1 wr_d_s |=> ##1 $stable(dacCodes)) else $error("async hold");
  a_imm_update: assert property (
    tk && c == QDCC_CMD_WRITE_IN && wordData[18:16] == 3'h0 && channel_update_mask[0]
    |-> ##2 dacCodes[15:0] == $past(wordData[15:0], 2)) else $error("immediate");
  a_start_level: assert property (
    $fell(inReset) |=> dacCodes == {4{powerOnLevel ? QDCC_MID_CODE : QDCC_ZERO_CODE}}) else $error("level");
endmodule

bind quad_dac_control_commands qdcc_props #(.DATA_W(DATA_W)) i_qdcc_props (.clk(clk), .nrst(nrst),
  .wordValid(wordValid), .wordData(wordData), .load_strobe_n(load_strobe_n), .powerOnLevel(powerOnLevel),
  .dacCodes(dacCodes), .powerModes(powerModes), .channel_update_mask(channel_update_mask),
  .reference_enable(reference_enable), .inReset(inReset));

// *** bench/quad_dac_control_commands_bench.sv ***
`timescale 1ns/1ps
module quad_dac_control_commands_bench;
  import qdcc_pkg::*;
  logic        clk, nrst, strobeN, clrN, level, wordValid, refEn, inReset, eRef;
  logic [23:0] wordData;
  logic [63:0] dacCodes, eIn, eDac;
  logic [7:0]  powerModes, ePwr;
  logic [3:0]  mask, eMask, ePend;
  logic [76:0] eq[$];
  int          dq[$];
  int          cyc, n_errors, num_checks;

  quad_dac_control_commands i_quad_dac_control_commands (.clk(clk), .nrst(nrst), .wordValid(wordValid),
    .wordData(wordData), .load_strobe_n(strobeN), .clear_input_n(clrN), .powerOnLevel(level),
    .dacCodes(dacCodes), .powerModes(powerModes), .channel_update_mask(mask), .reference_enable(refEn),
    .inReset(inReset));
  qdcc_host i_qdcc_host (.clk(clk), .wordValid(wordValid), .wordData(wordData));

  always #20 clk = ~clk;

  task automatic final_report();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      n_errors++;
      final_report();
    end
  end

  task automatic chk(input string nm, input logic [76:0] seen, input logic [76:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s exp %h seen %h", nm, exp, seen);
    end
  endtask

  // oldest note against settled outputs
  always @(negedge clk) begin
    if (dq.size() > 0 && dq[0] <= cyc) begin
      chk("outputs", {mask, powerModes, refEn, dacCodes}, eq[0]);
      void'(eq.pop_front());
      void'(dq.pop_front());
    end
  end

  task automatic note(input int due);
    eq.push_back({eMask, ePwr, eRef, eDac});
    dq.push_back(due);
  endtask

  task automatic cmd(input logic [2:0] c, input logic [2:0] a, input logic [15:0] d);
    i_qdcc_host.send({2'h0, c, a, d});
    #1;
    for (int ch = 0; ch < 4; ch++) begin
      case (c)
        3'h0, 3'h3: if (a == 3'(ch) || a == QDCC_ADDR_ALL) begin
          eIn[ch*16 +: 16] = d;
          ePend[ch] = (c == 3'h0) && !eMask[ch];
          if (!ePend[ch]) eDac[ch*16 +: 16] = d;
        end
        3'h1: if (a == 3'(ch) || a == QDCC_ADDR_ALL) begin
          eDac[ch*16 +: 16] = eIn[ch*16 +: 16];
          ePend[ch] = 1'b0;
        end
        3'h2: begin
          if (a == 3'(ch) || a == QDCC_ADDR_ALL) eIn[ch*16 +: 16] = d;
          eDac[ch*16 +: 16] = eIn[ch*16 +: 16];
          ePend[ch] = 1'b0;
        end
        3'h4: if (d[ch]) ePwr[ch*2 +: 2] = d[5:4];
        3'h5: begin
          {eIn, eDac, ePend} = '0;
          if (d[0]) {eMask, ePwr, eRef} = '0;
        end
        3'h6: eMask = d[3:0];
        default: eRef = d[0];
      endcase
    end
    note(cyc + 1);
  endtask

  task automatic strobe();
    @(posedge clk) strobeN <= 1'b0;
    repeat (6) @(posedge clk);
    strobeN <= 1'b1;
    #1;
    for (int ch = 0; ch < 4; ch++) begin
      if (ePend[ch]) eDac[ch*16 +: 16] = eIn[ch*16 +: 16];
    end
    ePend = '0;
    note(cyc);
  endtask

  // strobe and clear move while reset holds
  task automatic rst(input logic lv);
    repeat (3) @(posedge clk);
    nrst    <= 1'b0;
    level   <= lv;
    strobeN <= 1'b0;
    clrN    <= 1'($urandom);
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    repeat (2) @(posedge clk);
    strobeN <= 1'b1;
    #1;
    chk("inReset", 77'(inReset), 77'h1);
    repeat (6) @(posedge clk);
    #1;
    chk("inReset", 77'(inReset), 77'h0);
    eDac = {4{lv ? QDCC_MID_CODE : QDCC_ZERO_CODE}};
    {eIn, ePend, eMask, ePwr, eRef} = '0;
    note(cyc);
  endtask

  initial begin
    clk = 1'b0;
    nrst = 1'b0;
    strobeN = 1'b1;
    clrN = 1'b1;
    level = 1'b1;
    cyc = 0;
    n_errors = 0;
    num_checks = 0;
    void'($urandom(65));
    rst(1'b1);
    for (int i = 0; i < 6; i++) cmd(3'h6, 3'($urandom), 16'($urandom));
    for (int m = 0; m < 4; m++) cmd(3'h4, 3'($urandom), {10'($urandom), 2'(m), 4'($urandom)});
    cmd(3'h7, 3'($urandom), 16'h0001);
    cmd(3'h7, 3'($urandom), 16'h0000);
    cmd(3'h6, 3'h2, 16'h0001);
    cmd(3'h0, 3'h0, 16'($urandom));
    repeat (6) @(posedge clk);
    cmd(3'h0, 3'h3, 16'($urandom));
    strobe();
    cmd(3'h3, QDCC_ADDR_ALL, 16'($urandom));
    cmd(3'h4, 3'h1, 16'h003f);
    cmd(3'h0, 3'h1, 16'($urandom));
    cmd(3'h1, 3'h1, 16'($urandom));
    cmd(3'h2, 3'h2, 16'($urandom));
    cmd(3'h5, 3'h4, 16'h0000);
    cmd(3'h7, 3'h0, 16'h0001);
    cmd(3'h5, 3'h4, 16'h0001);
    rst(1'b0);
    repeat (3) @(posedge clk);
    final_report();
  end
endmodule

// *** hw/qdcc_pkg.sv ***
package qdcc_pkg;
  localparam int          QDCC_CHANNELS    = 4;
  localparam int          QDCC_DATA_W      = 16;
  localparam int          QDCC_WORD_W      = 24;
  // command word field positions
  localparam int          QDCC_CMD_MSB     = 21;
  localparam int          QDCC_CMD_LSB     = 19;
  localparam int          QDCC_ADDR_MSB    = 18;
  localparam int          QDCC_ADDR_LSB    = 16;
  localparam int          QDCC_PMODE_MSB   = 5;
  localparam int          QDCC_PMODE_LSB   = 4;
  localparam int          QDCC_SEL_MSB     = 3;
  localparam int          QDCC_SEL_LSB     = 0;
  localparam int          QDCC_SCOPE_BIT   = 0;
  localparam int          QDCC_REF_BIT     = 0;
  localparam logic [2:0]  QDCC_ADDR_ALL    = 3'h7;
  // reset values
  localparam logic [3:0]  QDCC_MASK_RST    = 4'h0;
  localparam logic        QDCC_REF_RST     = 1'h0;
  localparam logic [15:0] QDCC_ZERO_CODE   = 16'h0000;
  localparam logic [15:0] QDCC_MID_CODE    = 16'h8000;

  typedef enum logic [2:0] {
    QDCC_CMD_WRITE_IN   = 3'h0,
    QDCC_CMD_UPDATE     = 3'h1,
    QDCC_CMD_WRITE_ALL  = 3'h2,
    QDCC_CMD_WRITE_UPD  = 3'h3,
    QDCC_CMD_POWER      = 3'h4,
    QDCC_CMD_RESET      = 3'h5,
    QDCC_CMD_LOADMASK   = 3'h6,
    QDCC_CMD_REFERENCE  = 3'h7
  } qdcc_cmd_t;

  typedef enum logic [1:0] {
    QDCC_PWR_NORMAL     = 2'h0,
    QDCC_PWR_PD_1K      = 2'h1,
    QDCC_PWR_PD_100K    = 2'h2,
    QDCC_PWR_HIGHZ      = 2'h3
  } qdcc_pwr_t;

  typedef struct packed {
    logic        valid;
    logic [23:0] word;
  } qdcc_word_t;

  typedef struct packed {
    logic [3:0]  cmdValid;
    logic [3:0]  upd;
  } qdcc_dummy_t;
endpackage

// *** hw/qdcc_sync.sv ***
`timescale 1ns/1ps
module qdcc_sync (
  // clock and reset
  input  wire logic clk,
  input  wire logic nrst,
  // pin side
  input  wire logic pinIn,
  // synchronised
  output logic      pinOut
);
  logic stage1Reg;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      stage1Reg <= 1'h1;
      pinOut    <= 1'h1;
    end else begin
      stage1Reg <= pinIn;
      pinOut    <= stage1Reg;
    end
  end
endmodule

// *** hw/quad_dac_control_commands.sv ***
`timescale 1ns/1ps
module quad_dac_control_commands
  import qdcc_pkg::*;
#(
  parameter int  DATA_W     = QDCC_DATA_W,
  parameter bit  HAS_STROBE = 1'b1,
  parameter bit  HAS_LEVEL  = 1'b1
) (
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   nrst,
  // framed command word from serial interface
  input  wire logic                   wordValid,
  input  wire logic [QDCC_WORD_W-1:0] wordData,
  // pins
  input  wire logic                   load_strobe_n,
  input  wire logic                   clear_input_n,
  input  wire logic                   powerOnLevel,
  // outputs
  output logic [4*DATA_W-1:0]         dacCodes,
  output logic [7:0]                  powerModes,
  output logic [3:0]                  channel_update_mask,
  output logic                        reference_enable,
  output logic                        inReset
);
  logic              strobeSync;
  logic              clearSync;
  logic              strobeLast;
  logic              levelReg;
  logic              levelNext;
  logic [2:0]        porCountReg;
  logic [DATA_W-1:0] inputReg   [QDCC_CHANNELS];
  logic [DATA_W-1:0] dacReg     [QDCC_CHANNELS];
  logic [3:0]        pendingReg;
  logic [3:0]        chanSel;
  logic [3:0]        maskSel;
  logic [3:0]        writeSel;
  logic [3:0]        updSel;
  logic              strobeFall;
  logic              hardReset;
  logic              softReset;
  qdcc_cmd_t         cmd;
  logic [DATA_W-1:0] dataField;

  qdcc_sync u_strobe (
    .clk    (clk),
    .nrst   (nrst),
    .pinIn  (load_strobe_n),
    .pinOut (strobeSync)
  );

  qdcc_sync u_clear (
    .clk    (clk),
    .nrst   (nrst),
    .pinIn  (clear_input_n),
    .pinOut (clearSync)
  );

  qdcc_sync u_level (
    .clk    (clk),
    .nrst   (nrst),
    .pinIn  (powerOnLevel),
    .pinOut (levelNext)
  );

  function automatic logic [3:0] addr_decode(input logic [2:0] a);
    logic [3:0] r;
    r = 4'h0;
    if (a == QDCC_ADDR_ALL) begin
      r = 4'hf;
    end else if (a[2] == 1'b0) begin
      r[a[1:0]] = 1'b1;
    end
    return r;
  endfunction

  assign cmd       = qdcc_cmd_t'(wordData[QDCC_CMD_MSB:QDCC_CMD_LSB]);
  assign chanSel   = addr_decode(wordData[QDCC_ADDR_MSB:QDCC_ADDR_LSB]);
  assign maskSel   = wordData[QDCC_SEL_MSB:QDCC_SEL_LSB];
  assign dataField = wordData[15 -: DATA_W];

  assign softReset = wordValid && (cmd == QDCC_CMD_RESET);
  assign hardReset = softReset && wordData[QDCC_SCOPE_BIT];

  assign strobeFall = HAS_STROBE && !inReset && strobeLast && !strobeSync;

  // reset hold: wait for synchronisers to settle
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      porCountReg <= 3'h0;
      inReset     <= 1'h1;
    end else if (porCountReg != 3'h3) begin
      porCountReg <= porCountReg + 3'h1;
    end else begin
      inReset     <= 1'h0;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      levelReg <= 1'h0;
    // level synchroniser shows its reset value for two edges
    end else if (inReset && porCountReg >= 3'h2) begin
      levelReg <= HAS_LEVEL ? levelNext : 1'b0;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      strobeLast <= 1'h1;
    end else begin
      strobeLast <= strobeSync;
    end
  end

  always_comb begin
    writeSel = 4'h0;
    updSel   = 4'h0;
    if (wordValid && !inReset) begin
      case (cmd)
        QDCC_CMD_WRITE_IN: begin
          writeSel = chanSel;
        end
        QDCC_CMD_UPDATE: begin
          updSel = chanSel;
        end
        QDCC_CMD_WRITE_ALL: begin
          writeSel = chanSel;
          updSel   = 4'hf;
        end
        QDCC_CMD_WRITE_UPD: begin
          writeSel = chanSel;
          updSel   = chanSel;
        end
        default: begin
          writeSel = 4'h0;
        end
      endcase
    end
  end

  // input registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < QDCC_CHANNELS; i++) begin
        inputReg[i] <= QDCC_ZERO_CODE[DATA_W-1:0];
      end
    end else if (inReset || softReset) begin
      for (int i = 0; i < QDCC_CHANNELS; i++) begin
        inputReg[i] <= levelReg && !softReset ? QDCC_MID_CODE[DATA_W-1:0] : QDCC_ZERO_CODE[DATA_W-1:0];
      end
    end else begin
      for (int i = 0; i < QDCC_CHANNELS; i++) begin
        if (writeSel[i]) begin
          inputReg[i] <= dataField;
        end
      end
    end
  end

  // pending marks input written since last update command or strobe fall
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pendingReg <= 4'h0;
    end else if (inReset || softReset) begin
      pendingReg <= 4'h0;
    end else begin
      for (int i = 0; i < QDCC_CHANNELS; i++) begin
        if (writeSel[i]) begin
          pendingReg[i] <= 1'b1;
        end else if (updSel[i] || strobeFall) begin
          pendingReg[i] <= 1'b0;
        end
      end
    end
  end

  // DAC registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < QDCC_CHANNELS; i++) begin
        dacReg[i] <= QDCC_ZERO_CODE[DATA_W-1:0];
      end
    end else if (inReset || softReset) begin
      // hold reset level until an update, a strobe fall or a masked write
      for (int i = 0; i < QDCC_CHANNELS; i++) begin
        dacReg[i] <= levelReg && !softReset ? QDCC_MID_CODE[DATA_W-1:0] : QDCC_ZERO_CODE[DATA_W-1:0];
      end
    end else begin
      for (int i = 0; i < QDCC_CHANNELS; i++) begin
        if (writeSel[i] && channel_update_mask[i]) begin
          dacReg[i] <= dataField;
        end else if (writeSel[i] && updSel[i]) begin
          dacReg[i] <= dataField;
        end else if (updSel[i]) begin
          dacReg[i] <= inputReg[i];
        end else if (strobeFall && pendingReg[i]) begin
          dacReg[i] <= inputReg[i];
        end
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      channel_update_mask <= QDCC_MASK_RST;
    end else if (inReset) begin
      channel_update_mask <= QDCC_MASK_RST;
    end else if (hardReset) begin
      channel_update_mask <= QDCC_MASK_RST;
    end else if (wordValid && cmd == QDCC_CMD_LOADMASK) begin
      channel_update_mask <= maskSel;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      powerModes <= 8'h00;
    end else if (inReset || hardReset) begin
      powerModes <= 8'h00;
    end else if (wordValid && cmd == QDCC_CMD_POWER) begin
      for (int i = 0; i < QDCC_CHANNELS; i++) begin
        // two-bit mode field stored as is
        if (maskSel[i]) begin
          powerModes[2*i +: 2] <= wordData[QDCC_PMODE_MSB:QDCC_PMODE_LSB];
        end
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      reference_enable <= QDCC_REF_RST;
    end else if (inReset || hardReset) begin
      reference_enable <= QDCC_REF_RST;
    end else if (wordValid && cmd == QDCC_CMD_REFERENCE) begin
      reference_enable <= wordData[QDCC_REF_BIT];
    end
  end

  // codes leave untouched by power mode
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      dacCodes <= '0;
    end else begin
      for (int i = 0; i < QDCC_CHANNELS; i++) begin
        dacCodes[i*DATA_W +: DATA_W] <= dacReg[i];
      end
    end
  end

  // clear pin is synchronised; its action lies outside this block
  logic clearSeen;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      clearSeen <= 1'h0;
    end else if (!inReset) begin
      clearSeen <= !clearSync;
    end
  end
endmodule
